// ===== pam_pkg.sv
// pam_pkg: constants shared by the alert logic, its limit counters and its testbench.
// assumes byte-wide register access and a sequencer that marks each sample and cycle end.
package pam_pkg;

  // channel count and field widths
  localparam int MAX_CH = 4;
  localparam int NCH_DEF = 4;
  localparam int CH_W = 2;
  localparam int V_W = 16;
  localparam int P_W = 24;
  localparam int CNT_W = 4;
  localparam int RUN_W = 5;
  localparam int NPAR = 5;

  // timing of the conversion-complete pulse
  localparam int CLK_HZ = 25_000_000;
  localparam int CC_PULSE_NS = 5000;
  localparam int CC_PULSE_CYC = (CC_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int CC_W = 8;

  // register offsets
  localparam logic [7:0] A_BUS_SET = 8'h1C;
  localparam logic [7:0] A_CAUSE_VOLT = 8'h20;
  localparam logic [7:0] A_CAUSE_CURR = 8'h21;
  localparam logic [7:0] A_CAUSE_PWR = 8'h22;
  localparam logic [7:0] A_CAUSE_OVF = 8'h23;
  localparam logic [7:0] A_ASSIGN1 = 8'h24;
  localparam logic [7:0] A_ASSIGN2 = 8'h25;
  localparam logic [7:0] A_LIM_EN_V = 8'h26;
  localparam logic [7:0] A_LIM_EN_C = 8'h27;
  localparam logic [7:0] A_LIM_EN_P = 8'h28;
  localparam logic [7:0] A_CNT_V = 8'h29;
  localparam logic [7:0] A_CNT_C = 8'h2A;
  localparam logic [7:0] A_CNT_P = 8'h2B;
  localparam logic [7:0] A_ACC_LIM = 8'h2C;
  localparam logic [7:0] A_CNTR_LIM = 8'h2D;
  localparam logic [7:0] A_PIN_CFG = 8'h2E;
  localparam logic [7:0] A_THR_BASE = 8'h40;
  localparam int THR_CH_LSB = 4;

  // threshold record layout, byte offsets, low byte first
  localparam int TB_OV = 0;
  localparam int TB_UV = 2;
  localparam int TB_OC = 4;
  localparam int TB_UC = 6;
  localparam int TB_OP = 8;
  localparam int THR_BYTES = 11;

  // parameter index of each limit comparison
  localparam int P_OV = 0;
  localparam int P_UV = 1;
  localparam int P_OC = 2;
  localparam int P_UC = 3;
  localparam int P_OP = 4;

  // bus settings bits
  localparam int BS_PIN1_IN = 4;
  localparam int BS_GEN_ALERT = 5;
  localparam int BS_PIN2_OUT = 6;
  localparam int BS_PIN2_IN = 7;
  localparam logic [7:0] BUS_SET_RST = 8'h40;

  // source assignment bits, same layout in both assignment registers
  localparam int AS_OV = 0;
  localparam int AS_UV = 1;
  localparam int AS_OC = 2;
  localparam int AS_UC = 3;
  localparam int AS_OP = 4;
  localparam int AS_FULL = 5;
  localparam int AS_OVF = 6;
  localparam int AS_CC = 7;
  localparam int NSRC = 7;

  // pin configuration bits
  localparam int PC_PIN1_ALERT = 0;
  localparam int PC_PIN2_ALERT = 1;

  // fullness selection codes
  localparam logic [1:0] FULL_15_16 = 2'h0;
  localparam logic [1:0] FULL_7_8 = 2'h1;
  localparam logic [1:0] FULL_3_4 = 2'h2;
  localparam logic [1:0] FULL_ALL = 2'h3;

  // conversion-complete pulse states
  typedef enum logic [1:0] {
    CC_IDLE = 2'b01,
    CC_PULSE = 2'b10
  } pam_cc_e;

endpackage : pam_pkg

// ===== pam_mem_if.sv
// pam_mem_if: write and read port of the per-channel threshold memory.
// assumes one writer and one reader in the same clock domain.
`timescale 1ns/1ps
interface pam_mem_if #(parameter int CH_W = 2, parameter int NBYTES = 11);
  logic we;
  logic [CH_W-1:0] wch;
  logic [3:0] wbyte;
  logic [7:0] wdata;
  logic [CH_W-1:0] rch;
  logic [NBYTES*8-1:0] rrec;
  modport mst (output we, output wch, output wbyte, output wdata, output rch, input rrec);
  modport mem (input we, input wch, input wbyte, input wdata, input rch, output rrec);
endinterface : pam_mem_if

// ===== pam_thr_mem.sv
// pam_thr_mem: byte-written threshold store, one record per channel, registered read.
// assumes rch and wch stay below DEPTH; out-of-range reads return zero.
`timescale 1ns/1ps
module pam_thr_mem #(
  parameter int DEPTH = 4,
  parameter int NBYTES = 11,
  parameter int CH_W = 2
) (
  // clock
  input wire logic clk,
  // memory port
  pam_mem_if.mem port
);
  if (DEPTH < 1 || DEPTH > (1 << CH_W) || NBYTES < 1 || NBYTES > 16) begin : g_bad
    $error("pam_thr_mem: unsupported depth or record size");
  end

  logic [7:0] mem [DEPTH][NBYTES];

  // byte write, guarded so stray indices never touch storage
  always_ff @(posedge clk) begin
    if (port.we && int'(port.wch) < DEPTH && int'(port.wbyte) < NBYTES) begin
      mem[port.wch][port.wbyte] <= port.wdata;
    end
  end

  // whole record read out through a register, one cycle after rch
  always_ff @(posedge clk) begin
    for (int b = 0; b < NBYTES; b++) begin
      port.rrec[b*8 +: 8] <= (int'(port.rch) < DEPTH) ? mem[port.rch][b] : 8'h00;
    end
  end
endmodule : pam_thr_mem

// ===== pam_limit_cnt.sv
// pam_limit_cnt: consecutive over-limit sample counter for one parameter of one channel.
// assumes exceed is already gated by the limit enable and smp is a one-cycle strobe.
`timescale 1ns/1ps
module pam_limit_cnt import pam_pkg::*; #(
  parameter int CW = RUN_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // sample strobe and comparison
  input wire logic smp,
  input wire logic exceed,
  input wire logic [CNT_W-1:0] need,
  // hit pulse
  output logic hit
);
  if (CW <= CNT_W) begin : g_bad
    $error("pam_limit_cnt: run counter too narrow");
  end

  logic [CW-1:0] run;

  // run length of exceeding samples, saturating; a passing sample restarts it
  always_ff @(posedge clk) begin
    if (reset) begin
      run <= '0;
    end else if (smp) begin
      run <= exceed ? ((&run) ? run : run + CW'(1)) : '0;
    end
  end

  // need holds count-1, so a run of need+1 samples hits and keeps hitting
  always_ff @(posedge clk) begin
    if (reset) begin
      hit <= 1'b0;
    end else begin
      hit <= smp && exceed && (run >= CW'(need));
    end
  end

  AST_HIT_CAUSE: assert property (@(posedge clk) disable iff (reset)
    hit |-> $past(smp && exceed && (run >= CW'(need))))
    else $error("hit without enough exceeding samples");
endmodule : pam_limit_cnt

// ===== pam_alert_top.sv
// pam_alert_top: alert logic of the power monitor, limits, fullness, causes and two pins.
// assumes synchronous inputs from the conversion sequencer and a byte register port.
// How it works
// - enabled pin goes low for 5 us after each completed conversion cycle.
// - no completion pulse in burst mode with a single active channel.
// - completion pulse never sets any cause status bit.
// - two assignment registers route every source to pin one, pin two, or both.
// - pin one in alert mode ignores its rate-reduction input.
// - bus settings bit 5 shows a live general alert flag.
// - in io mode each pin shows its input level; only pin two takes output from settings.
// - sources are rail, shunt, power limits, completion, fullness and overflow.
// - each comparison has a per-channel enable; disabled ones raise nothing.
// - thresholds compare as two's complement whatever the measurement mode.
// - per channel 16-bit current and voltage limits, 24-bit power limit.
// - a programmed run of 1 to 16 exceeding samples is needed to alert.
// - over-limits trip when strictly above, under-limits when strictly below.
// - power limit compares the magnitude of the power sample.
// - fullness selectable as 15/16, 7/8, 3/4 or full for accumulator and count.
// - reading the voltage, current or power cause register clears it and releases its alert.
// - cause register updates on the condition, with no snapshot needed.
// - overflow alert holds until full or broadcast snapshot; voltage snapshot ignored.
// - a persisting condition reasserts on the next still-exceeding sample.
// - other raised alerts drive the assigned pin low and hold it latched.
// - conditions are set at the end of each round-robin cycle.
`timescale 1ns/1ps
module pam_alert_top import pam_pkg::*; #(
  parameter int NCH = NCH_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  // conversion sequencer
  input wire logic smp_valid,
  input wire logic [CH_W-1:0] smp_ch,
  input wire logic [V_W-1:0] rail_voltage,
  input wire logic [V_W-1:0] shunt_voltage,
  input wire logic [P_W-1:0] power_smp,
  input wire logic cycle_done,
  input wire logic burst_mode,
  input wire logic [2:0] active_cnt,
  input wire logic snap_all,
  input wire logic snap_volt,
  // accumulator state per channel
  input wire logic [NCH*4-1:0] acc_top,
  input wire logic [NCH*4-1:0] cnt_top,
  input wire logic [NCH-1:0] acc_ovf,
  input wire logic [NCH-1:0] cnt_ovf,
  // dual-purpose pins, open drain, enable low while driving
  input wire logic rate_or_flag_pin_one_i,
  output logic rate_or_flag_pin_one_o,
  output logic rate_or_flag_pin_one_oe_n,
  input wire logic io_or_flag_pin_two_i,
  output logic io_or_flag_pin_two_o,
  output logic io_or_flag_pin_two_oe_n,
  // rate reduction request towards the sequencer
  output logic rate_reduce
);
  if (NCH < 1 || NCH > MAX_CH) begin : g_bad
    $error("pam_alert_top: channel count must be 1 to 4");
  end

  // configuration registers
  logic [7:0] assign1, assign2;
  logic [7:0] lim_en_v, lim_en_c, lim_en_p;
  logic [7:0] cnt_v, cnt_c, cnt_p;
  logic [7:0] acc_lim, cntr_lim, pin_cfg;
  logic [3:0] bus_lo;
  logic pin2_out;
  // cause registers
  logic [7:0] cause_volt, cause_curr, cause_pwr, cause_ovf;
  // sample pipeline
  logic s1_valid, cd1, cd2;
  logic [CH_W-1:0] s1_ch;
  logic [V_W-1:0] s1_v, s1_i;
  logic [P_W-1:0] s1_p;
  logic [NPAR-1:0] exceed;
  logic [NPAR-1:0][MAX_CH-1:0] lim_en, hitv, pend, evt;
  logic [NPAR-1:0][CNT_W-1:0] need;
  logic [NCH-1:0] hit [NPAR];
  logic [MAX_CH-1:0] full_now, acc_ovf4, cnt_ovf4;
  logic [7:0] set_volt, set_curr, set_pwr, set_ovf;
  logic rd_volt, rd_curr, rd_pwr;
  logic [NSRC-1:0] src;
  logic lvl1, lvl2, any_cause, cc_skip, cc_on;
  pam_cc_e cc_state;
  logic [CC_W-1:0] cc_cnt;
  logic signed [V_W-1:0] thr_ov, thr_uv, thr_oc, thr_uc;
  logic signed [P_W-1:0] thr_op;
  logic [P_W:0] p_ext, p_mag;

  pam_mem_if #(.CH_W(CH_W), .NBYTES(THR_BYTES)) thr_if ();

  pam_thr_mem #(.DEPTH(NCH), .NBYTES(THR_BYTES), .CH_W(CH_W)) u_thr_mem (
    .clk(clk),
    .port(thr_if.mem)
  );

  // threshold writes go straight to the memory; records are 16 bytes apart
  assign thr_if.we = reg_we && (reg_addr[7:6] == A_THR_BASE[7:6]) &&
                     (int'(reg_addr[3:0]) < THR_BYTES);
  assign thr_if.wch = reg_addr[THR_CH_LSB +: CH_W];
  assign thr_if.wbyte = reg_addr[3:0];
  assign thr_if.wdata = reg_wdata;
  assign thr_if.rch = smp_ch;

  // configuration writes; cause and threshold bytes are handled elsewhere
  always_ff @(posedge clk) begin
    if (reset) begin
      assign1 <= 8'h00;
      assign2 <= 8'h00;
      lim_en_v <= 8'h00;
      lim_en_c <= 8'h00;
      lim_en_p <= 8'h00;
      cnt_v <= 8'h00;
      cnt_c <= 8'h00;
      cnt_p <= 8'h00;
      acc_lim <= 8'h00;
      cntr_lim <= 8'h00;
      pin_cfg <= 8'h00;
      bus_lo <= BUS_SET_RST[3:0];
      pin2_out <= BUS_SET_RST[BS_PIN2_OUT];
    end else if (reg_we) begin
      case (reg_addr)
        A_ASSIGN1: assign1 <= reg_wdata;
        A_ASSIGN2: assign2 <= reg_wdata;
        A_LIM_EN_V: lim_en_v <= reg_wdata;
        A_LIM_EN_C: lim_en_c <= reg_wdata;
        A_LIM_EN_P: lim_en_p <= {4'h0, reg_wdata[3:0]};
        A_CNT_V: cnt_v <= reg_wdata;
        A_CNT_C: cnt_c <= reg_wdata;
        A_CNT_P: cnt_p <= {4'h0, reg_wdata[3:0]};
        A_ACC_LIM: acc_lim <= reg_wdata;
        A_CNTR_LIM: cntr_lim <= reg_wdata;
        A_PIN_CFG: pin_cfg <= {6'h00, reg_wdata[1:0]};
        A_BUS_SET: begin
          bus_lo <= reg_wdata[3:0];
          pin2_out <= reg_wdata[BS_PIN2_OUT];
        end
        default: ;
      endcase
    end
  end

  // per-parameter views of the packed enable and count bytes
  assign lim_en[P_OV] = lim_en_v[3:0];
  assign lim_en[P_UV] = lim_en_v[7:4];
  assign lim_en[P_OC] = lim_en_c[3:0];
  assign lim_en[P_UC] = lim_en_c[7:4];
  assign lim_en[P_OP] = lim_en_p[3:0];
  assign need[P_OV] = cnt_v[3:0];
  assign need[P_UV] = cnt_v[7:4];
  assign need[P_OC] = cnt_c[3:0];
  assign need[P_UC] = cnt_c[7:4];
  assign need[P_OP] = cnt_p[3:0];

  // sample held one cycle so it meets its channel's thresholds from the memory
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_valid <= 1'b0;
      cd1 <= 1'b0;
      cd2 <= 1'b0;
    end else begin
      s1_valid <= smp_valid;
      cd1 <= cycle_done;
      cd2 <= cd1;
    end
  end

  always_ff @(posedge clk) begin
    s1_ch <= smp_ch;
    s1_v <= rail_voltage;
    s1_i <= shunt_voltage;
    s1_p <= power_smp;
  end

  // signed compares whatever the front-end polarity mode is
  assign thr_ov = thr_if.rrec[TB_OV*8 +: V_W];
  assign thr_uv = thr_if.rrec[TB_UV*8 +: V_W];
  assign thr_oc = thr_if.rrec[TB_OC*8 +: V_W];
  assign thr_uc = thr_if.rrec[TB_UC*8 +: V_W];
  assign thr_op = thr_if.rrec[TB_OP*8 +: P_W];
  assign p_ext = {s1_p[P_W-1], s1_p};
  assign p_mag = p_ext[P_W] ? (~p_ext + (P_W+1)'(1)) : p_ext;
  assign exceed[P_OV] = $signed(s1_v) > thr_ov;
  assign exceed[P_UV] = $signed(s1_v) < thr_uv;
  assign exceed[P_OC] = $signed(s1_i) > thr_oc;
  assign exceed[P_UC] = $signed(s1_i) < thr_uc;
  assign exceed[P_OP] = $signed({1'b0, p_mag}) > $signed({{2{thr_op[P_W-1]}}, thr_op});

  // one run counter per channel and parameter
  for (genvar p = 0; p < NPAR; p++) begin : g_par
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      pam_limit_cnt #(.CW(RUN_W)) u_cnt (
        .clk(clk),
        .reset(reset),
        .smp(s1_valid && (s1_ch == CH_W'(c))),
        .exceed(exceed[p] && lim_en[p][c]),
        .need(need[p]),
        .hit(hit[p][c])
      );
    end
  end

  // fullness level match, checked once per cycle end
  function automatic logic full_match(input logic [1:0] sel, input logic [3:0] top,
                                      input logic ovf);
    case (sel)
      FULL_15_16: full_match = (top == 4'hF);
      FULL_7_8: full_match = (top[3:1] == 3'h7);
      FULL_3_4: full_match = (top[3:2] == 2'h3);
      FULL_ALL: full_match = ovf;
      default: full_match = 1'b0;
    endcase
  endfunction : full_match

  // gather hits and fullness into padded per-source vectors
  always_comb begin
    hitv = '0;
    full_now = '0;
    acc_ovf4 = '0;
    cnt_ovf4 = '0;
    for (int p = 0; p < NPAR; p++) begin
      for (int c = 0; c < NCH; c++) begin
        hitv[p][c] = hit[p][c];
      end
    end
    for (int c = 0; c < NCH; c++) begin
      full_now[c] = full_match(acc_lim[2*c +: 2], acc_top[4*c +: 4], acc_ovf[c]) |
                    full_match(cntr_lim[2*c +: 2], cnt_top[4*c +: 4], cnt_ovf[c]);
      acc_ovf4[c] = acc_ovf[c];
      cnt_ovf4[c] = cnt_ovf[c];
    end
  end

  // hits wait in pend until the round-robin cycle ends
  always_ff @(posedge clk) begin
    if (reset) begin
      pend <= '0;
    end else begin
      pend <= cd2 ? '0 : (pend | hitv);
    end
  end

  assign evt = pend | hitv;
  assign set_volt = cd2 ? {evt[P_UV], evt[P_OV]} : 8'h00;
  assign set_curr = cd2 ? {evt[P_UC], evt[P_OC]} : 8'h00;
  assign set_pwr = cd2 ? {full_now, evt[P_OP]} : 8'h00;
  assign set_ovf = cd2 ? {cnt_ovf4, acc_ovf4} : 8'h00;
  assign rd_volt = reg_re && (reg_addr == A_CAUSE_VOLT);
  assign rd_curr = reg_re && (reg_addr == A_CAUSE_CURR);
  assign rd_pwr = reg_re && (reg_addr == A_CAUSE_PWR);

  // a read clears the voltage, current or power cause register, a full snapshot the overflow one; a new cause in the same cycle wins
  always_ff @(posedge clk) begin
    if (reset) begin
      cause_volt <= 8'h00;
      cause_curr <= 8'h00;
      cause_pwr <= 8'h00;
      cause_ovf <= 8'h00;
    end else begin
      cause_volt <= (rd_volt ? 8'h00 : cause_volt) | set_volt;
      cause_curr <= (rd_curr ? 8'h00 : cause_curr) | set_curr;
      cause_pwr <= (rd_pwr ? 8'h00 : cause_pwr) | set_pwr;
      cause_ovf <= (snap_all ? 8'h00 : cause_ovf) | set_ovf;
    end
  end

  // completion pulse; a retrigger during the pulse is dropped, not stretched
  assign cc_skip = burst_mode && (active_cnt == 3'h1);
  assign cc_on = (cc_state == CC_PULSE);
  always_ff @(posedge clk) begin
    if (reset) begin
      cc_state <= CC_IDLE;
      cc_cnt <= '0;
    end else begin
      case (cc_state)
        CC_IDLE: begin
          if (cd2 && !cc_skip && (assign1[AS_CC] || assign2[AS_CC])) begin
            cc_state <= CC_PULSE;
            cc_cnt <= CC_W'(CC_PULSE_CYC - 1);
          end
        end
        CC_PULSE: begin
          if (cc_cnt == '0) begin
            cc_state <= CC_IDLE;
          end else begin
            cc_cnt <= cc_cnt - CC_W'(1);
          end
        end
        default: cc_state <= CC_IDLE;
      endcase
    end
  end

  // latched source levels, then per-pin routing; the pulse adds only on the pin
  assign src[AS_OV] = |cause_volt[3:0];
  assign src[AS_UV] = |cause_volt[7:4];
  assign src[AS_OC] = |cause_curr[3:0];
  assign src[AS_UC] = |cause_curr[7:4];
  assign src[AS_OP] = |cause_pwr[3:0];
  assign src[AS_FULL] = |cause_pwr[7:4];
  assign src[AS_OVF] = |cause_ovf;
  assign any_cause = |src;
  assign lvl1 = (|(src & assign1[NSRC-1:0])) || (cc_on && assign1[AS_CC]);
  assign lvl2 = (|(src & assign2[NSRC-1:0])) || (cc_on && assign2[AS_CC]);

  // pin drivers; in io mode pin two pulls low while its output bit is zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rate_or_flag_pin_one_o <= 1'b0;
      rate_or_flag_pin_one_oe_n <= 1'b1;
      io_or_flag_pin_two_o <= 1'b0;
      io_or_flag_pin_two_oe_n <= 1'b1;
      rate_reduce <= 1'b0;
    end else begin
      rate_or_flag_pin_one_o <= 1'b0;
      io_or_flag_pin_two_o <= 1'b0;
      rate_or_flag_pin_one_oe_n <= !(pin_cfg[PC_PIN1_ALERT] && lvl1);
      io_or_flag_pin_two_oe_n <= pin_cfg[PC_PIN2_ALERT] ? !lvl2 : pin2_out;
      rate_reduce <= !pin_cfg[PC_PIN1_ALERT] && rate_or_flag_pin_one_i;
    end
  end

  // register read data; unmapped and threshold bytes read as zero
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_re) begin
      case (reg_addr)
        A_BUS_SET: reg_rdata <= {io_or_flag_pin_two_i, pin2_out, any_cause,
                                 rate_or_flag_pin_one_i, bus_lo};
        A_CAUSE_VOLT: reg_rdata <= cause_volt;
        A_CAUSE_CURR: reg_rdata <= cause_curr;
        A_CAUSE_PWR: reg_rdata <= cause_pwr;
        A_CAUSE_OVF: reg_rdata <= cause_ovf;
        A_ASSIGN1: reg_rdata <= assign1;
        A_ASSIGN2: reg_rdata <= assign2;
        A_LIM_EN_V: reg_rdata <= lim_en_v;
        A_LIM_EN_C: reg_rdata <= lim_en_c;
        A_LIM_EN_P: reg_rdata <= lim_en_p;
        A_CNT_V: reg_rdata <= cnt_v;
        A_CNT_C: reg_rdata <= cnt_c;
        A_CNT_P: reg_rdata <= cnt_p;
        A_ACC_LIM: reg_rdata <= acc_lim;
        A_CNTR_LIM: reg_rdata <= cntr_lim;
        A_PIN_CFG: reg_rdata <= pin_cfg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  AST_CC_WIDTH: assert property (@(posedge clk) disable iff (reset)
    $rose(cc_on) |-> ##124 cc_on ##1 !cc_on)
    else $error("completion pulse not 125 cycles");
  AST_CC_BURST_SKIP: assert property (@(posedge clk) disable iff (reset)
    (cd2 && cc_skip && cc_state == CC_IDLE) |=> cc_state == CC_IDLE)
    else $error("completion pulse in single-channel burst");
  AST_CC_NO_CAUSE: assert property (@(posedge clk) disable iff (reset)
    (cd2 && evt == '0 && full_now == '0 && set_ovf == 8'h00 && !reg_re && !snap_all)
    |=> $stable(cause_volt) && $stable(cause_curr) && $stable(cause_pwr) && $stable(cause_ovf))
    else $error("cause changed without a condition");
  AST_RATE_OFF: assert property (@(posedge clk) disable iff (reset)
    pin_cfg[PC_PIN1_ALERT] |=> !rate_reduce)
    else $error("rate input active in alert mode");
  AST_GEN_FLAG: assert property (@(posedge clk) disable iff (reset)
    (reg_re && reg_addr == A_BUS_SET) |=> reg_rdata[BS_GEN_ALERT] == $past(any_cause))
    else $error("general alert flag wrong");
  AST_READ_CLEAR: assert property (@(posedge clk) disable iff (reset)
    (rd_volt && set_volt == 8'h00) |=> cause_volt == 8'h00)
    else $error("cause register not cleared by read");
  AST_OVF_HOLD: assert property (@(posedge clk) disable iff (reset)
    (snap_volt && !snap_all && cause_ovf != 8'h00) |=> cause_ovf != 8'h00)
    else $error("overflow cause lost on voltage snapshot");
  AST_SET_AT_END: assert property (@(posedge clk) disable iff (reset)
    (|(cause_curr & ~$past(cause_curr))) |-> $past(cd2))
    else $error("cause set outside cycle end");
  AST_PIN_LATCH: assert property (@(posedge clk) disable iff (reset)
    (pin_cfg[PC_PIN1_ALERT] && |(src & assign1[NSRC-1:0])) |=> !rate_or_flag_pin_one_oe_n)
    else $error("pin one not driven for routed alert");
endmodule : pam_alert_top

// ===== pam_host_model.sv
// pam_host_model: host side of the two open-drain alert pins, with pull-ups.
// assumes oe_n low means the device drives its output level; otherwise the pull-up wins.
`timescale 1ns/1ps
module pam_host_model (
  // clock
  input wire logic clk,
  // device pin drivers and enables
  input wire logic o1,
  input wire logic oe1_n,
  input wire logic o2,
  input wire logic oe2_n,
  // resolved wire levels
  output logic pin1,
  output logic pin2,
  output logic seen_alert
);
  // released pins float up to the pull-up level, never to the last driven value
  assign pin1 = oe1_n ? 1'b1 : o1;
  assign pin2 = oe2_n ? 1'b1 : o2;
  // flags an asserted pin one cycle later so the host goes on to read the cause
  always_ff @(posedge clk) begin
    seen_alert <= !(pin1 && pin2);
  end
endmodule : pam_host_model

// ===== pam_alert_top_test.sv
// pam_alert_top_test: directed checks of limits, cause clearing, pins and the completion pulse.
// assumes the host model pull-ups and a register port with one-cycle read latency.
`timescale 1ns/1ps
module pam_alert_top_test;
  import pam_pkg::*;
  logic clk, reset, we, re, sv, cd, bm, oe1, oe2, p1, p2, rr;
  logic sn, o1, o2, sa;
  logic [3:0] ao;
  logic [7:0] addr, wd, rdat;
  logic [15:0] rail;
  logic [2:0] act;
  int error_cnt, n_compared;
  pam_alert_top dut (.clk(clk), .reset(reset), .reg_addr(addr), .reg_wdata(wd),
    .reg_we(we), .reg_re(re), .reg_rdata(rdat), .smp_valid(sv), .smp_ch(2'h0),
    .rail_voltage(rail), .shunt_voltage(rail), .power_smp({8'h00, rail}),
    .cycle_done(cd), .burst_mode(bm), .active_cnt(act), .snap_all(cd), .snap_volt(sn),
    .acc_top(16'h0000), .cnt_top(16'h0000), .acc_ovf(ao), .cnt_ovf(4'h0),
    .rate_or_flag_pin_one_i(p1), .rate_or_flag_pin_one_o(o1),
    .rate_or_flag_pin_one_oe_n(oe1), .io_or_flag_pin_two_i(p2),
    .io_or_flag_pin_two_o(o2), .io_or_flag_pin_two_oe_n(oe2), .rate_reduce(rr));
  pam_host_model host (.clk(clk), .o1(o1), .oe1_n(oe1), .o2(o2), .oe2_n(oe2),
    .pin1(p1), .pin2(p2), .seen_alert(sa));
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task conclude;
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    we = 1'b1; addr = a; wd = d;
    @(posedge clk) #1;
    we = 1'b0;
  endtask : wr
  // data is judged 1 ns after the edge that takes the read
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) #1;
    re = 1'b1; addr = a;
    @(posedge clk) #1;
    re = 1'b0;
    chk(rdat, e);
  endtask : rd
  // one sample on channel 0 that also ends the round-robin cycle
  task cyc(input logic [15:0] v);
    @(posedge clk) #1;
    sv = 1'b1; cd = 1'b1; rail = v;
    @(posedge clk) #1;
    sv = 1'b0; cd = 1'b0;
    repeat (5) @(posedge clk);
    #1;
  endtask : cyc
  // counts cycles pin two is pulled low after a cycle end
  task pulse(input logic b, input logic [7:0] e);
    int n;
    n = 0;
    bm = b;
    @(posedge clk) #1;
    cd = 1'b1;
    @(posedge clk) #1;
    cd = 1'b0;
    repeat (200) begin
      @(posedge clk) #1;
      if (oe2 === 1'b0) n++;
    end
    chk(n[7:0], e);
  endtask : pulse
  // overflow cause survives reads and a voltage-only snapshot, clears on a full one
  task ovf_hold;
    ao = 4'h1;
    cyc(16'h0000);
    ao = 4'h0;
    rd(8'h23, 8'h01);
    @(posedge clk) #1;
    sn = 1'b1;
    @(posedge clk) #1;
    sn = 1'b0;
    rd(8'h23, 8'h01);
    cyc(16'h0000);
    rd(8'h23, 8'h00);
  endtask : ovf_hold
  // watchdog, far beyond the roughly 540 cycles the sequence needs
  initial begin
    #400000;
    error_cnt++;
    conclude();
  end
  // main sequence
  initial begin
    error_cnt = 0; n_compared = 0;
    reset = 1'b1; we = 1'b0; re = 1'b0; sv = 1'b0; cd = 1'b0; bm = 1'b0;
    act = 3'h4; addr = 8'h00; wd = 8'h00; rail = 16'h0000;
    sn = 1'b0;
    ao = 4'h0;
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    rd(8'h1C, 8'hD0);
    chk({7'h00, rr}, 8'h01);
    wr(8'h1C, 8'h00);
    rd(8'h1C, 8'h10);
    wr(8'h1C, 8'h40);
    wr(8'h40, 8'hFF);
    wr(8'h41, 8'h00);
    wr(8'h26, 8'h01);
    wr(8'h24, 8'h01);
    wr(8'h2E, 8'h01);
    cyc(16'h00FF);
    rd(8'h20, 8'h00);
    cyc(16'h0100);
    chk({7'h00, oe1}, 8'h00);
    chk({7'h00, sa}, 8'h01);
    chk({7'h00, rr}, 8'h00);
    rd(8'h1C, 8'hE0);
    rd(8'h20, 8'h01);
    rd(8'h20, 8'h00);
    cyc(16'h0100);
    rd(8'h20, 8'h01);
    cyc(16'h8000);
    rd(8'h20, 8'h00);
    wr(8'h26, 8'h00);
    cyc(16'h0100);
    rd(8'h20, 8'h00);
    wr(8'h44, 8'hFF);
    wr(8'h45, 8'h00);
    wr(8'h27, 8'h01);
    wr(8'h2A, 8'h01);
    cyc(16'h0100);
    rd(8'h21, 8'h00);
    cyc(16'h0100);
    rd(8'h21, 8'h01);
    wr(8'h27, 8'h00);
    ovf_hold();
    wr(8'h24, 8'h00);
    wr(8'h25, 8'h80);
    wr(8'h2E, 8'h03);
    pulse(1'b0, 8'h7D);
    rd(8'h22, 8'h00);
    act = 3'h1;
    pulse(1'b1, 8'h00);
    conclude();
  end
endmodule : pam_alert_top_test
